// >>> dv/nasc_equip_model.sv
// Behavioural model of the appliance answering forwarded accesses
`timescale 1ns/100ps
module nasc_equip_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic fwd_valid,
    input wire logic [7:0] fwd_cmd,
    input wire logic [3:0] fwd_prop,
    // Silent mode: never answers, provokes the timeout
    input wire logic mute,
    // Extra answer delay in cycles
    input wire logic [2:0] dly,
    output logic eq_rsp_valid,
    output logic [7:0] eq_rsp_cmd,
    output logic [15:0] eq_rsp_data
);
    logic [3:0] cnt_q;
    logic [7:0] pcmd_q;
    logic [15:0] pdata_q;

    // Answer after delay; released bus shows inverted last value
    always @(posedge mclk) begin
        eq_rsp_valid <= 1'b0;
        if (sys_rst) begin
            cnt_q <= 4'h0;
            eq_rsp_cmd <= 8'h00;
            eq_rsp_data <= 16'h0000;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            // Answer code pairs with request code
            if (cnt_q == 4'h1) begin
                eq_rsp_valid <= 1'b1;
                eq_rsp_cmd <= pcmd_q;
                eq_rsp_data <= pdata_q;
            end
        end else if (fwd_valid && !mute) begin
            cnt_q <= {1'b0, dly} + 4'h1;
            pcmd_q <= (fwd_cmd == nasc_pkg::CMD_ELEM_REQ) ? nasc_pkg::CMD_ELEM_RSP
                : nasc_pkg::CMD_ACCESS_RSP;
            pdata_q <= {12'hc00, fwd_prop};
        end
        // Hold time over: drive inverse, not stale data
        if (eq_rsp_valid) begin
            eq_rsp_cmd <= ~eq_rsp_cmd;
            eq_rsp_data <= ~eq_rsp_data;
        end
    end
endmodule

// >>> dv/test_network_adapter_service_state_control.sv
// Self-checking bench for the adapter state and service control
`timescale 1ns/100ps
module test_network_adapter_service_state_control;
    logic mclk, sys_rst, recog_done, frm_valid, confirm_ok, confirm_fail;
    logic init_ok, init_fail, construct_ok, construct_fail, normal_fail;
    logic cfg_we, cfg_exists, cfg_passthru, cfg_needinit, eq_we;
    logic net_valid, net_write, net_elem, eq_rsp_valid, mute;
    logic discrepancy_err, net_join_en, mw_cold_start, err_proc, fwd_valid;
    logic [1:0] frm_class, net_ans;
    logic [2:0] state, dly;
    logic [3:0] cfg_prop, eq_prop, net_prop, fwd_prop;
    logic [7:0] eq_rsp_cmd, fwd_cmd, seen_cmd;
    logic [15:0] eq_wdata, net_wdata, eq_rsp_data, err_code, fwd_data, net_rdata, eq_rdata;
    logic [15:0] d;
    logic seen_disc, seen_proc;
    int bad_count, tests_run, cyc, n, i;

    nasc_ctrl #(.PROP_W(4), .DATA_W(16), .TIMEOUT(16)) u_nasc_ctrl (.mclk(mclk),
        .sys_rst(sys_rst), .recog_done(recog_done), .frm_valid(frm_valid),
        .frm_class(frm_class), .confirm_ok(confirm_ok), .confirm_fail(confirm_fail),
        .init_ok(init_ok), .init_fail(init_fail), .construct_ok(construct_ok),
        .construct_fail(construct_fail), .normal_fail(normal_fail), .cfg_we(cfg_we),
        .cfg_prop(cfg_prop), .cfg_exists(cfg_exists), .cfg_passthru(cfg_passthru),
        .cfg_needinit(cfg_needinit), .eq_we(eq_we), .eq_prop(eq_prop),
        .eq_wdata(eq_wdata), .net_valid(net_valid), .net_write(net_write),
        .net_elem(net_elem), .net_prop(net_prop), .net_wdata(net_wdata),
        .eq_rsp_valid(eq_rsp_valid), .eq_rsp_cmd(eq_rsp_cmd), .eq_rsp_data(eq_rsp_data),
        .state(state), .discrepancy_err(discrepancy_err), .net_join_en(net_join_en),
        .mw_cold_start(mw_cold_start), .err_proc(err_proc), .err_code(err_code),
        .fwd_valid(fwd_valid), .fwd_cmd(fwd_cmd), .fwd_prop(fwd_prop),
        .fwd_data(fwd_data), .net_ans(net_ans), .net_rdata(net_rdata), .eq_rdata(eq_rdata));

    nasc_equip_model u_nasc_equip_model (.mclk(mclk), .sys_rst(sys_rst),
        .fwd_valid(fwd_valid), .fwd_cmd(fwd_cmd), .fwd_prop(fwd_prop), .mute(mute),
        .dly(dly), .eq_rsp_valid(eq_rsp_valid), .eq_rsp_cmd(eq_rsp_cmd),
        .eq_rsp_data(eq_rsp_data));

    // Property table: 0-11 exist, 8-11 pass-through, 5 needs initial value
    function automatic logic f_pt(input logic [3:0] p);
        return p[3:2] == 2'b10;
    endfunction
    function automatic logic [15:0] f_mdl(input logic [3:0] p);
        return {12'hc00, p};
    endfunction

    // Clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    // Collect pulse outputs over three cycles
    task automatic watch3();
        seen_disc = 1'b0;
        seen_proc = 1'b0;
        repeat (3) begin
            if (discrepancy_err === 1'b1) seen_disc = 1'b1;
            if (err_proc === 1'b1) seen_proc = 1'b1;
            tick();
        end
    endtask

    // One-cycle event pulse by index
    task automatic ev(input int k);
        case (k)
            0: confirm_ok = 1'b1;
            1: confirm_fail = 1'b1;
            2: init_ok = 1'b1;
            3: init_fail = 1'b1;
            4: construct_ok = 1'b1;
            5: construct_fail = 1'b1;
            6: normal_fail = 1'b1;
            default: recog_done = 1'b1;
        endcase
        tick();
        {confirm_ok, confirm_fail, init_ok, init_fail} = 4'h0;
        {construct_ok, construct_fail, normal_fail, recog_done} = 4'h0;
        watch3();
    endtask

    task automatic frame(input logic [1:0] cls, input logic xerr);
        frm_valid = 1'b1;
        frm_class = cls;
        tick();
        frm_valid = 1'b0;
        watch3();
        chk("discrepancy_err", {15'h0, xerr}, {15'h0, seen_disc});
    endtask

    // Network request; waits bounded for answer, notes any forward
    task automatic svc(input logic w, input logic e, input logic [3:0] p,
        input logic [15:0] wd, input logic [1:0] xans, input logic [7:0] xcmd,
        input logic [15:0] xd);
        net_valid = 1'b1;
        net_write = w;
        net_elem = e;
        net_prop = p;
        net_wdata = wd;
        tick();
        net_valid = 1'b0;
        seen_cmd = 8'h00;
        n = 0;
        while (net_ans === 2'h0 && n < 40) begin
            if (fwd_valid === 1'b1) begin
                seen_cmd = fwd_cmd;
                chk("fwd_data", wd, fwd_data);
                chk("fwd_prop", {12'h0, p}, {12'h0, fwd_prop});
            end
            tick();
            n++;
        end
        chk("net_ans", {14'h0, xans}, {14'h0, net_ans});
        chk("fwd_cmd", {8'h0, xcmd}, {8'h0, seen_cmd});
        if (!w && xans == nasc_pkg::ANS_ACCEPT) chk("net_rdata", xd, net_rdata);
        if (xcmd == 8'h00 && xans != nasc_pkg::ANS_NONE) chk("fast_ans", 16'h1, {15'h0, n <= 1});
        tick();
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {recog_done, frm_valid, confirm_ok, confirm_fail, init_ok, init_fail} = 6'h0;
        {construct_ok, construct_fail, normal_fail, cfg_we, cfg_exists} = 5'h0;
        {cfg_passthru, cfg_needinit, eq_we, net_valid, net_write, net_elem, mute} = 7'h0;
        {frm_class, dly, cfg_prop, eq_prop, net_prop, eq_wdata, net_wdata} = 49'h0;
        sys_rst = 1'b1;
        void'($urandom(32'hafc2));
        repeat (5) tick();
        sys_rst = 1'b0;
        chk("state", 16'h0, {13'h0, state});
        chk("err_code", nasc_pkg::ERR_NONE, err_code);
        frame(nasc_pkg::FRM_OTHER, 1'b1);
        frame(nasc_pkg::FRM_CONFIRM, 1'b0);
        svc(1'b0, 1'b0, 4'h1, 16'h0, nasc_pkg::ANS_NONE, 8'h00, 16'h0);
        for (i = 0; i < 3; i++) begin
            ev(1);
            chk("state", (i == 2) ? 16'h5 : 16'h0, {13'h0, state});
        end
        ev(7);
        chk("state", 16'h0, {13'h0, state});
        ev(0);
        chk("state", 16'h1, {13'h0, state});
        frame(nasc_pkg::FRM_OTHER, 1'b1);
        frame(nasc_pkg::FRM_CONSTRUCT, 1'b1);
        frame(nasc_pkg::FRM_INIT, 1'b0);
        chk("state", 16'h2, {13'h0, state});
        chk("mw_cold_start", 16'h1, {15'h0, mw_cold_start});
        chk("net_join_en", 16'h0, {15'h0, net_join_en});
        frame(nasc_pkg::FRM_OTHER, 1'b1);
        frame(nasc_pkg::FRM_CONSTRUCT, 1'b0);
        // Per-property handling table
        for (i = 0; i < 16; i++) begin
            cfg_we = 1'b1;
            cfg_prop = i[3:0];
            cfg_exists = i < 12;
            cfg_passthru = f_pt(i[3:0]);
            cfg_needinit = i == 5;
            tick();
        end
        cfg_we = 1'b0;
        ev(5);
        chk("state", 16'h3, {13'h0, state});
        chk("err_code", nasc_pkg::ERR_OBJECT, err_code);
        chk("err_proc", 16'h1, {15'h0, seen_proc});
        frame(nasc_pkg::FRM_INIT, 1'b0);
        ev(3);
        chk("err_code", nasc_pkg::ERR_INIT, err_code);
        frame(nasc_pkg::FRM_INIT, 1'b0);
        ev(2);
        construct_ok = 1'b1;
        tick();
        construct_ok = 1'b0;
        n = 0;
        while (fwd_valid !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk("scan_cmd", {8'h0, nasc_pkg::CMD_ACCESS_REQ}, {8'h0, fwd_cmd});
        chk("scan_prop", 16'h5, {12'h0, fwd_prop});
        repeat (20) tick();
        chk("state", 16'h4, {13'h0, state});
        chk("net_join_en", 16'h1, {15'h0, net_join_en});
        svc(1'b0, 1'b0, 4'h5, 16'h0, nasc_pkg::ANS_ACCEPT, 8'h00, f_mdl(4'h5));
        // Random stored writes read back, equipment sees them too
        for (i = 0; i < 8; i++) begin
            net_prop = 4'($urandom % 8);
            d = 16'($urandom);
            svc(1'b1, 1'b0, net_prop, d, nasc_pkg::ANS_ACCEPT, 8'h00, 16'h0);
            svc(1'b0, 1'b0, net_prop, 16'h0, nasc_pkg::ANS_ACCEPT, 8'h00, d);
            eq_prop = net_prop;
            tick();
            tick();
            chk("eq_rdata", d, eq_rdata);
        end
        // Equipment refreshes a stored value
        eq_we = 1'b1;
        eq_prop = 4'h2;
        eq_wdata = 16'($urandom);
        tick();
        eq_we = 1'b0;
        svc(1'b0, 1'b0, 4'h2, 16'h0, nasc_pkg::ANS_ACCEPT, 8'h00, eq_wdata);
        svc(1'b1, 1'b0, 4'hd, 16'h1234, nasc_pkg::ANS_REJECT, 8'h00, 16'h0);
        svc(1'b0, 1'b1, 4'he, 16'h0, nasc_pkg::ANS_REJECT, 8'h00, 16'h0);
        // Every pass-through kind, write/read by element or whole
        for (i = 0; i < 4; i++) begin
            dly = 3'($urandom % 4);
            svc(i[0], i[1], 4'h8 + i[3:0], 16'($urandom), nasc_pkg::ANS_ACCEPT,
                i[1] ? nasc_pkg::CMD_ELEM_REQ : nasc_pkg::CMD_ACCESS_REQ,
                f_mdl(4'h8 + i[3:0]));
        end
        mute = 1'b1;
        svc(1'b1, 1'b0, 4'ha, 16'h5a5a, nasc_pkg::ANS_REJECT,
            nasc_pkg::CMD_ACCESS_REQ, 16'h0);
        chk("timeout_len", 16'h1, {15'h0, n >= 15});
        svc(1'b1, 1'b1, 4'hb, 16'ha5a5, nasc_pkg::ANS_REJECT,
            nasc_pkg::CMD_ELEM_REQ, 16'h0);
        mute = 1'b0;
        frame(nasc_pkg::FRM_CONSTRUCT, 1'b1);
        ev(6);
        chk("state", 16'h3, {13'h0, state});
        chk("err_code", nasc_pkg::ERR_OTHER, err_code);
        chk("err_proc", 16'h1, {15'h0, seen_proc});
        svc(1'b0, 1'b0, 4'h2, 16'h0, nasc_pkg::ANS_NONE, 8'h00, 16'h0);
        tally_and_finish();
    end
endmodule

// >>> rtl/nasc_ctrl.sv
// Adapter state machine and property service engine
`timescale 1ns/100ps
module nasc_ctrl #(
    parameter int PROP_W = 4,
    parameter int DATA_W = 16,
    parameter int TIMEOUT = nasc_pkg::TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    // Recognition process done, re-enter confirmation
    input wire logic recog_done,
    // Appliance-side frame in, with class
    input wire logic frm_valid,
    input wire logic [1:0] frm_class,
    // Confirmation outcome pulses
    input wire logic confirm_ok,
    input wire logic confirm_fail,
    // Sequence outcomes during construction
    input wire logic init_ok,
    input wire logic init_fail,
    input wire logic construct_ok,
    input wire logic construct_fail,
    // Failure during normal operation
    input wire logic normal_fail,
    // Per-property mode load: 1 pass-through, 0 stored
    input wire logic cfg_we,
    input wire logic [PROP_W-1:0] cfg_prop,
    input wire logic cfg_exists,
    input wire logic cfg_passthru,
    input wire logic cfg_needinit,
    // Equipment writes to local storage
    input wire logic eq_we,
    input wire logic [PROP_W-1:0] eq_prop,
    input wire logic [DATA_W-1:0] eq_wdata,
    // Network service request
    input wire logic net_valid,
    input wire logic net_write,
    input wire logic net_elem,
    input wire logic [PROP_W-1:0] net_prop,
    input wire logic [DATA_W-1:0] net_wdata,
    // Equipment answer to a forwarded request
    input wire logic eq_rsp_valid,
    input wire logic [7:0] eq_rsp_cmd,
    input wire logic [DATA_W-1:0] eq_rsp_data,
    // Outputs
    output logic [2:0] state,
    output logic discrepancy_err,
    output logic net_join_en,
    output logic mw_cold_start,
    output logic err_proc,
    output logic [15:0] err_code,
    output logic fwd_valid,
    output logic [7:0] fwd_cmd,
    output logic [PROP_W-1:0] fwd_prop,
    output logic [DATA_W-1:0] fwd_data,
    output logic [1:0] net_ans,
    output logic [DATA_W-1:0] net_rdata,
    output logic [DATA_W-1:0] eq_rdata
);
    localparam int NPROP = 1 << PROP_W;
    // Adapter state
    nasc_pkg::nasc_state_t st_q, st_d;
    nasc_pkg::nasc_svc_t sv_q;
    logic [1:0] fails_q;
    logic [15:0] err_q;
    logic disc_q, join_q, cold_q, errp_q;
    // Sequence successes seen so far in construction
    logic init_seen_q, build_seen_q;
    // Per-property tables and storage
    logic [DATA_W-1:0] store_q [NPROP];
    logic exists_q [NPROP];
    logic passthru_q [NPROP];
    logic needinit_q [NPROP];
    // Forward and answer outputs
    logic fwd_q;
    logic [7:0] fcmd_q;
    logic [PROP_W-1:0] fprop_q, pend_q, scan_q;
    logic [DATA_W-1:0] fdata_q, rdata_q;
    logic [1:0] ans_q;
    logic pwrite_q, pinit_q;
    logic [31:0] tmo_q;

    // Frame acceptance per state
    wire frm_ok_confirm = frm_class == nasc_pkg::FRM_CONFIRM;
    wire frm_ok_standby = frm_class == nasc_pkg::FRM_INIT;
    wire frm_ok_build = frm_class == nasc_pkg::FRM_INIT
        || frm_class == nasc_pkg::FRM_CONSTRUCT;
    wire frm_ok_normal = frm_class != nasc_pkg::FRM_CONSTRUCT;
    wire is_init = frm_valid && frm_class == nasc_pkg::FRM_INIT;
    logic frm_accept;
    always_comb begin
        case (st_q)
            nasc_pkg::NASC_CONFIRM: frm_accept = frm_ok_confirm;
            nasc_pkg::NASC_STANDBY: frm_accept = frm_ok_standby;
            nasc_pkg::NASC_CONSTRUCT: frm_accept = frm_ok_build;
            nasc_pkg::NASC_ERRSTOP: frm_accept = frm_ok_standby;
            nasc_pkg::NASC_NORMAL: frm_accept = frm_ok_normal;
            default: frm_accept = 1'b0;
        endcase
    end

    // Each sequence may finish in a different cycle
    wire init_good = init_ok || init_seen_q;
    wire build_good = construct_ok || build_seen_q;

    // Next adapter state
    always_comb begin
        st_d = st_q;
        case (st_q)
            nasc_pkg::NASC_CONFIRM: begin
                if (confirm_ok) begin
                    st_d = nasc_pkg::NASC_STANDBY;
                end else if (confirm_fail && fails_q == nasc_pkg::CONFIRM_TRIES - 2'h1) begin
                    st_d = nasc_pkg::NASC_UNRECOG;
                end
            end
            nasc_pkg::NASC_STANDBY: begin
                if (is_init) begin
                    st_d = nasc_pkg::NASC_CONSTRUCT;
                end
            end
            nasc_pkg::NASC_CONSTRUCT: begin
                if (init_fail || construct_fail) begin
                    st_d = nasc_pkg::NASC_ERRSTOP;
                end else if (init_good && build_good) begin
                    st_d = nasc_pkg::NASC_NORMAL;
                end
            end
            nasc_pkg::NASC_ERRSTOP: begin
                if (is_init) begin
                    st_d = nasc_pkg::NASC_CONSTRUCT;
                end
            end
            nasc_pkg::NASC_NORMAL: begin
                if (is_init) begin
                    st_d = nasc_pkg::NASC_CONSTRUCT;
                end else if (normal_fail) begin
                    st_d = nasc_pkg::NASC_ERRSTOP;
                end
            end
            default: st_d = st_q;
        endcase
        if (recog_done) begin
            st_d = nasc_pkg::NASC_CONFIRM;
        end
    end

    // Error code chosen by cause on entry to error stop
    wire [15:0] err_d = (st_q == nasc_pkg::NASC_NORMAL) ? nasc_pkg::ERR_OTHER
        : construct_fail ? nasc_pkg::ERR_OBJECT : nasc_pkg::ERR_INIT;
    wire enter_err = st_d == nasc_pkg::NASC_ERRSTOP && st_q != nasc_pkg::NASC_ERRSTOP;
    wire enter_norm = st_d == nasc_pkg::NASC_NORMAL && st_q != nasc_pkg::NASC_NORMAL;
    wire in_normal = st_q == nasc_pkg::NASC_NORMAL;

    // State, counters and status flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= nasc_pkg::NASC_CONFIRM;
            fails_q <= 2'h0;
            err_q <= nasc_pkg::ERR_NONE;
            disc_q <= 1'b0;
            join_q <= 1'b0;
            cold_q <= 1'b0;
            errp_q <= 1'b0;
            init_seen_q <= 1'b0;
            build_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            fails_q <= (st_d != nasc_pkg::NASC_CONFIRM) ? 2'h0
                : fails_q + {1'b0, confirm_fail};
            err_q <= enter_err ? err_d : err_q;
            disc_q <= frm_valid && !frm_accept;
            join_q <= st_d == nasc_pkg::NASC_NORMAL;
            cold_q <= st_d == nasc_pkg::NASC_CONSTRUCT;
            errp_q <= enter_err;
            // Successes kept only while construction goes on
            init_seen_q <= init_good && st_q == nasc_pkg::NASC_CONSTRUCT
                && st_d == nasc_pkg::NASC_CONSTRUCT;
            build_seen_q <= build_good && st_q == nasc_pkg::NASC_CONSTRUCT
                && st_d == nasc_pkg::NASC_CONSTRUCT;
        end
    end

    // Property table load and local storage
    always_ff @(posedge mclk) begin
        if (cfg_we) begin
            exists_q[cfg_prop] <= cfg_exists;
            passthru_q[cfg_prop] <= cfg_passthru;
            needinit_q[cfg_prop] <= cfg_needinit;
        end
        if (sv_q == nasc_pkg::NASC_SV_IDLE && net_valid && in_normal && net_write
            && exists_q[net_prop] && !passthru_q[net_prop]) begin
            store_q[net_prop] <= net_wdata;
        end else if (eq_we) begin
            store_q[eq_prop] <= eq_wdata;
        end else if (sv_q != nasc_pkg::NASC_SV_IDLE && eq_rsp_valid
            && (!pwrite_q || pinit_q)) begin
            store_q[pend_q] <= eq_rsp_data;
        end
    end

    // Service request decode
    wire req = sv_q == nasc_pkg::NASC_SV_IDLE && net_valid && in_normal;
    wire req_known = exists_q[net_prop];
    wire req_pass = passthru_q[net_prop];
    wire [7:0] req_cmd = net_elem ? nasc_pkg::CMD_ELEM_REQ : nasc_pkg::CMD_ACCESS_REQ;
    wire [7:0] want_rsp = fcmd_q == nasc_pkg::CMD_ELEM_REQ ? nasc_pkg::CMD_ELEM_RSP
        : nasc_pkg::CMD_ACCESS_RSP;
    wire rsp_hit = eq_rsp_valid && eq_rsp_cmd == want_rsp;
    wire tmo_hit = tmo_q == TIMEOUT - 1;
    wire scan_last = scan_q == PROP_W'(NPROP - 1);
    wire scan_need = exists_q[scan_q] && needinit_q[scan_q];

    // Service engine
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sv_q <= nasc_pkg::NASC_SV_IDLE;
            fwd_q <= 1'b0;
            fcmd_q <= 8'h00;
            fprop_q <= '0;
            fdata_q <= '0;
            pend_q <= '0;
            scan_q <= '0;
            rdata_q <= '0;
            ans_q <= nasc_pkg::ANS_NONE;
            pwrite_q <= 1'b0;
            pinit_q <= 1'b0;
            tmo_q <= 32'h0;
        end else begin
            fwd_q <= 1'b0;
            ans_q <= nasc_pkg::ANS_NONE;
            case (sv_q)
                nasc_pkg::NASC_SV_IDLE: begin
                    tmo_q <= 32'h0;
                    pinit_q <= 1'b0;
                    if (enter_norm) begin
                        scan_q <= '0;
                        pinit_q <= 1'b1;
                        sv_q <= nasc_pkg::NASC_SV_INIT;
                    end else if (req && !req_known) begin
                        ans_q <= nasc_pkg::ANS_REJECT;
                    end else if (req && !req_pass) begin
                        ans_q <= nasc_pkg::ANS_ACCEPT;
                        rdata_q <= store_q[net_prop];
                    end else if (req) begin
                        fwd_q <= 1'b1;
                        fcmd_q <= req_cmd;
                        fprop_q <= net_prop;
                        fdata_q <= net_wdata;
                        pend_q <= net_prop;
                        pwrite_q <= net_write;
                        sv_q <= nasc_pkg::NASC_SV_WAIT;
                    end
                end
                nasc_pkg::NASC_SV_WAIT: begin
                    tmo_q <= tmo_q + 32'h1;
                    if (rsp_hit || tmo_hit) begin
                        // Scan moves on to the next property either way
                        scan_q <= scan_q + PROP_W'(1);
                        sv_q <= (pinit_q && !scan_last) ? nasc_pkg::NASC_SV_INIT
                            : nasc_pkg::NASC_SV_IDLE;
                    end
                    if (rsp_hit) begin
                        rdata_q <= eq_rsp_data;
                        if (!pinit_q) begin
                            ans_q <= nasc_pkg::ANS_ACCEPT;
                        end
                    end else if (tmo_hit) begin
                        if (!pinit_q) begin
                            ans_q <= nasc_pkg::ANS_REJECT;
                        end
                    end
                end
                nasc_pkg::NASC_SV_INIT: begin
                    tmo_q <= 32'h0;
                    if (scan_need) begin
                        fwd_q <= 1'b1;
                        fcmd_q <= nasc_pkg::CMD_ACCESS_REQ;
                        fprop_q <= scan_q;
                        pend_q <= scan_q;
                        pwrite_q <= 1'b0;
                        sv_q <= nasc_pkg::NASC_SV_WAIT;
                    end else if (scan_last) begin
                        sv_q <= nasc_pkg::NASC_SV_IDLE;
                    end else begin
                        scan_q <= scan_q + PROP_W'(1);
                    end
                end
                default: sv_q <= nasc_pkg::NASC_SV_IDLE;
            endcase
            if (!in_normal && !enter_norm) begin
                sv_q <= nasc_pkg::NASC_SV_IDLE;
            end
        end
    end

    // Equipment readback of local storage
    always_ff @(posedge mclk) begin
        eq_rdata <= sys_rst ? '0 : store_q[eq_prop];
    end

    assign state = st_q;
    assign discrepancy_err = disc_q;
    assign net_join_en = join_q;
    assign mw_cold_start = cold_q;
    assign err_proc = errp_q;
    assign err_code = err_q;
    assign fwd_valid = fwd_q;
    assign fwd_cmd = fcmd_q;
    assign fwd_prop = fprop_q;
    assign fwd_data = fdata_q;
    assign net_ans = ans_q;
    assign net_rdata = rdata_q;

    // Checks
    a_err_code_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        st_q == nasc_pkg::NASC_NORMAL && normal_fail && !is_init && !recog_done
        |=> err_code == nasc_pkg::ERR_OTHER) else $error("wrong error code");
    a_join_only_normal: assert property (@(posedge mclk) disable iff (sys_rst)
        net_join_en |-> $past(st_d) == nasc_pkg::NASC_NORMAL)
        else $error("join outside normal");
    a_unknown_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        req && !req_known && !enter_norm |=> net_ans == nasc_pkg::ANS_REJECT && !fwd_valid)
        else $error("unknown property not rejected");
    a_fwd_timeout: assert property (@(posedge mclk) disable iff (sys_rst)
        sv_q == nasc_pkg::NASC_SV_WAIT && tmo_hit && !rsp_hit && !pinit_q && in_normal
        |=> net_ans == nasc_pkg::ANS_REJECT) else $error("no timeout reject");
    a_disc_frame: assert property (@(posedge mclk) disable iff (sys_rst)
        frm_valid && st_q == nasc_pkg::NASC_STANDBY && frm_class != nasc_pkg::FRM_INIT
        |=> discrepancy_err) else $error("no discrepancy error");
    a_init_to_build: assert property (@(posedge mclk) disable iff (sys_rst)
        is_init && st_q == nasc_pkg::NASC_ERRSTOP && !recog_done
        |=> st_q == nasc_pkg::NASC_CONSTRUCT && mw_cold_start)
        else $error("no construction entry");
    a_confirm_limit: assert property (@(posedge mclk) disable iff (sys_rst)
        st_q == nasc_pkg::NASC_CONFIRM && confirm_fail && !confirm_ok && fails_q == 2'h2
        && !recog_done |=> st_q == nasc_pkg::NASC_UNRECOG)
        else $error("no unrecognized state");
    a_build_exit: assert property (@(posedge mclk) disable iff (sys_rst)
        st_q == nasc_pkg::NASC_CONSTRUCT && init_fail && !recog_done
        |=> st_q == nasc_pkg::NASC_ERRSTOP && err_proc) else $error("no error stop");
    a_fwd_cmd_code: assert property (@(posedge mclk) disable iff (sys_rst)
        fwd_valid |-> fwd_cmd == nasc_pkg::CMD_ACCESS_REQ || fwd_cmd == nasc_pkg::CMD_ELEM_REQ)
        else $error("bad forward code");
    c_pass_ok: cover property (@(posedge mclk) fwd_valid ##[1:20] net_ans == nasc_pkg::ANS_ACCEPT);
    c_to_normal: cover property (@(posedge mclk) st_q == nasc_pkg::NASC_NORMAL);
    c_err_stop: cover property (@(posedge mclk) err_proc);
endmodule

// >>> rtl/nasc_pkg.sv
// Constants and types for the adapter service and state control block
package nasc_pkg;
    // Adapter top-level states
    typedef enum logic [2:0] {
        NASC_CONFIRM = 3'b000,
        NASC_STANDBY = 3'b001,
        NASC_CONSTRUCT = 3'b010,
        NASC_ERRSTOP = 3'b011,
        NASC_NORMAL = 3'b100,
        NASC_UNRECOG = 3'b101
    } nasc_state_t;
    // Service engine states
    typedef enum logic [1:0] {
        NASC_SV_IDLE = 2'b00,
        NASC_SV_WAIT = 2'b01,
        NASC_SV_INIT = 2'b10
    } nasc_svc_t;
    // Appliance-side frame classes
    localparam logic [1:0] FRM_CONFIRM = 2'h0;
    localparam logic [1:0] FRM_INIT = 2'h1;
    localparam logic [1:0] FRM_CONSTRUCT = 2'h2;
    localparam logic [1:0] FRM_OTHER = 2'h3;
    // Forwarded command codes
    localparam logic [7:0] CMD_ACCESS_REQ = 8'h10;
    localparam logic [7:0] CMD_ACCESS_RSP = 8'h90;
    localparam logic [7:0] CMD_ELEM_REQ = 8'h12;
    localparam logic [7:0] CMD_ELEM_RSP = 8'h92;
    // Error property codes
    localparam logic [15:0] ERR_OBJECT = 16'h03ea;
    localparam logic [15:0] ERR_INIT = 16'h03eb;
    localparam logic [15:0] ERR_OTHER = 16'h03ec;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    // Confirmation failure limit
    localparam logic [1:0] CONFIRM_TRIES = 2'h3;
    // Default equipment answer timeout, cycles at 25 MHz
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * 25;
    // Network answer codes
    localparam logic [1:0] ANS_ACCEPT = 2'h1;
    localparam logic [1:0] ANS_REJECT = 2'h2;
    localparam logic [1:0] ANS_NONE = 2'h0;
endpackage
